// ===== ocx_params.svh
// Purpose: Offsets, field positions and reset values of the compare control block
// Assumes: Word-indexed register port, 16-bit data
// Notes:   Definitions only
`ifndef OCX_PARAMS_SVH
`define OCX_PARAMS_SVH

// ==========================================================================
// Register indices
`define OCX_IDX_CON2        4'h0
`define OCX_IDX_IRQ_STAT    4'h1
`define OCX_IDX_IRQ_MASK    4'h2
`define OCX_IDX_FLT_STAT    4'h3

// ==========================================================================
// Control register fields
`define OCX_BIT_HOLD_SEL    15
`define OCX_BIT_FLT_LEVEL   14
`define OCX_BIT_FLT_FLOAT   13
`define OCX_BIT_POL_FLIP    12
`define OCX_BIT_CHAIN       8
`define OCX_BIT_TRIG_SEL    7
`define OCX_BIT_ARMED       6
`define OCX_BIT_PIN_FLOAT   5
`define OCX_SRC_HI          4
`define OCX_CON2_RESET      16'h000C
`define OCX_CON2_WMASK      16'hF1BF

// ==========================================================================
// Interrupt and fault status fields
`define OCX_IRQ_FAULT       0
`define OCX_IRQ_ARMED       1
`define OCX_IRQ_TRIGOUT     2
`define OCX_IRQ_WIDTH       3
`define OCX_FLT_LATCH       0

`endif

// ===== ocx_pkg.sv
// Purpose: Types shared by the compare control block
// Assumes: Nothing
// Notes:   Constants live in ocx_params.svh
package ocx_pkg;

    // ======================================================================
    // Fault state machine
    typedef enum logic [1:0]
    {
        OCX_FS_NORMAL = 2'b01,
        OCX_FS_FAULT  = 2'b10
    } ocx_fstate_type;

endpackage

// ===== ocx_fault_if.sv
// Purpose: Signals between the control top and the fault sequencer
// Assumes: One clock domain
// Notes:   No clocking block
`timescale 1ns/1ps
`default_nettype none

interface ocx_fault_if;
    logic faultSync;
    logic periodStart;
    logic holdSel;
    logic latchClr;
    logic faultActive;
    logic latchFlag;

    modport ctl
    (
        input  faultSync,
        input  periodStart,
        input  holdSel,
        input  latchClr,
        output faultActive,
        output latchFlag
    );

    modport top
    (
        output faultSync,
        output periodStart,
        output holdSel,
        output latchClr,
        input  faultActive,
        input  latchFlag
    );
endinterface

`default_nettype wire

// ===== ocx_fault_ctl.sv
// Purpose: Fault mode sequencer with software latch
// Assumes: faultSync already synchronised to ref_clk
// Notes:   Fault mode only ends on a period start
`timescale 1ns/1ps
`default_nettype none

module ocx_fault_ctl
(
    input  wire logic   ref_clk,
    input  wire logic   reset_n,
    ocx_fault_if.ctl    fi
);

    ocx_pkg::ocx_fstate_type stateFf;
    ocx_pkg::ocx_fstate_type nxt_state;
    logic                    latchFf;
    logic                    mayLeave;

    // ======================================================================
    // Latch: a new fault beats a software clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            latchFf <= 1'b0;
        else if (fi.faultSync)
            latchFf <= 1'b1;
        else if (fi.latchClr)
            latchFf <= 1'b0;
    end

    // ======================================================================
    // State machine
    // Leaving mid-period would glitch the output, so exit waits for a period start
    assign mayLeave = !fi.faultSync && fi.periodStart && (!fi.holdSel || !latchFf);

    always_comb
    begin
        nxt_state = stateFf;
        case (stateFf)
            ocx_pkg::OCX_FS_NORMAL:
                if (fi.faultSync)
                    nxt_state = ocx_pkg::OCX_FS_FAULT;
            ocx_pkg::OCX_FS_FAULT:
                if (mayLeave)
                    nxt_state = ocx_pkg::OCX_FS_NORMAL;
            default:
                nxt_state = ocx_pkg::OCX_FS_NORMAL;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            stateFf <= ocx_pkg::OCX_FS_NORMAL;
        else
            stateFf <= nxt_state;
    end

    assign fi.faultActive = (stateFf == ocx_pkg::OCX_FS_FAULT);
    assign fi.latchFlag   = latchFf;

    // ======================================================================
    // Checks
    hold_latched_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        fi.faultActive && fi.holdSel && latchFf && !fi.latchClr |=> fi.faultActive)
        else $error("fault mode left while latch still set");

    auto_exit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        fi.faultActive && !fi.holdSel && !fi.faultSync && fi.periodStart |=> !fi.faultActive)
        else $error("fault mode not left at period start");

    fault_present_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        fi.faultSync |=> fi.faultActive && latchFf)
        else $error("fault input did not hold fault mode");

endmodule

`default_nettype wire

// ===== ocx_control_two.sv
// Purpose: Second control register of a compare channel and its pin logic
// Assumes: Compare waveform, period start, enable and sources come from ref_clk logic
// Notes:   Fault pin is asynchronous and passes a two-stage synchroniser
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ocx_params.svh"

// Overview of operation
// - Hold set: exit needs latch cleared too
// - Hold clear: exit on no fault, period
// - Fault drives pin at fault level bit
// - Fault float bit tri-states pin on fault
// - Polarity flip bit inverts compare output
// - Chain bit enables 32-bit cascade
// - Trigger select: trigger or sync mode
// - Armed flag shows timer triggered, running
// - Armed flag hardware set, software writable
// - Pin float bit tri-states the output
// - Bits eleven to nine read zero
// - Turn-off emits trigger-out pulse
module ocx_control_two
(
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic [3:0]    regAddr,
    input  wire logic [15:0]   regWrData,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output logic      [15:0]   regRdData_ff,
    input  wire logic          faultPin,
    input  wire logic          compareRaw,
    input  wire logic          periodStart,
    input  wire logic          channelOn,
    input  wire logic [31:0]   sourcePulse,
    output logic               pinOut_ff,
    output logic               pinOe_ff,
    output logic               chainEn_ff,
    output logic               syncPulse_ff,
    output logic               timerRun_ff,
    output logic               trigOut_ff,
    output logic               irq_ff
);

    logic [15:0]               con2Ff;
    logic [15:0]               nxt_con2;
    logic [`OCX_IRQ_WIDTH-1:0] irqStatFf;
    logic [`OCX_IRQ_WIDTH-1:0] irqMaskFf;
    logic [`OCX_IRQ_WIDTH-1:0] events;
    logic                      faultMetaFf;
    logic                      faultSyncFf;
    logic                      faultActPrevFf;
    logic                      channelOnPrevFf;
    logic                      selPulse;
    logic                      hwArm;
    logic                      trigMode;
    logic                      offEdge;

    ocx_fault_if fi();

    // ======================================================================
    // Helpers
    function automatic logic wrHit(input logic [3:0] idx);
        wrHit = regWr && (regAddr == idx);
    endfunction

    function automatic logic rdHit(input logic [3:0] idx);
        rdHit = regRd && (regAddr == idx);
    endfunction

    // ======================================================================
    // Fault pin synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            faultMetaFf <= 1'b0;
            faultSyncFf <= 1'b0;
        end
        else
        begin
            faultMetaFf <= faultPin;
            faultSyncFf <= faultMetaFf;
        end
    end

    // ======================================================================
    // Fault sequencer
    assign fi.faultSync   = faultSyncFf;
    assign fi.periodStart = periodStart;
    assign fi.holdSel     = con2Ff[`OCX_BIT_HOLD_SEL];
    // Write one to clear; a fault in the same cycle still wins inside the sequencer
    assign fi.latchClr    = wrHit(`OCX_IDX_FLT_STAT) && regWrData[`OCX_FLT_LATCH];

    ocx_fault_ctl u_fault
    (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .fi      (fi)
    );

    // ======================================================================
    // Source selection
    // Index into sourcePulse; software must not point it at this channel
    assign selPulse = sourcePulse[con2Ff[`OCX_SRC_HI:0]];
    assign trigMode = con2Ff[`OCX_BIT_TRIG_SEL];
    assign hwArm    = trigMode && selPulse && channelOn;
    assign offEdge  = channelOnPrevFf && !channelOn;

    // ======================================================================
    // Control register
    always_comb
    begin
        nxt_con2 = con2Ff;
        if (wrHit(`OCX_IDX_CON2))
            nxt_con2 = regWrData & `OCX_CON2_WMASK;
        if (wrHit(`OCX_IDX_CON2))
            nxt_con2[`OCX_BIT_ARMED] = regWrData[`OCX_BIT_ARMED];
        if (hwArm)
            nxt_con2[`OCX_BIT_ARMED] = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            con2Ff <= `OCX_CON2_RESET;
        else
            con2Ff <= nxt_con2;
    end

    // ======================================================================
    // Pin drive
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pinOut_ff <= 1'b0;
            pinOe_ff  <= 1'b0;
        end
        else
        begin
            if (fi.faultActive)
                pinOut_ff <= con2Ff[`OCX_BIT_FLT_LEVEL];
            else
                pinOut_ff <= compareRaw ^ con2Ff[`OCX_BIT_POL_FLIP];
            pinOe_ff <= !(con2Ff[`OCX_BIT_PIN_FLOAT] ||
                          (fi.faultActive && con2Ff[`OCX_BIT_FLT_FLOAT]));
        end
    end

    // ======================================================================
    // Mode outputs
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            chainEn_ff   <= 1'b0;
            syncPulse_ff <= 1'b0;
            timerRun_ff  <= 1'b0;
        end
        else
        begin
            chainEn_ff   <= con2Ff[`OCX_BIT_CHAIN];
            syncPulse_ff <= !trigMode && selPulse;
            timerRun_ff  <= con2Ff[`OCX_BIT_ARMED];
        end
    end

    // ======================================================================
    // Trigger out on turn-off
    // Consumers must deselect this source before it is disabled
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            channelOnPrevFf <= 1'b0;
            trigOut_ff      <= 1'b0;
        end
        else
        begin
            channelOnPrevFf <= channelOn;
            trigOut_ff      <= offEdge;
        end
    end

    // ======================================================================
    // Interrupts
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            faultActPrevFf <= 1'b0;
        else
            faultActPrevFf <= fi.faultActive;
    end

    always_comb
    begin
        events                   = '0;
        events[`OCX_IRQ_FAULT]   = fi.faultActive && !faultActPrevFf;
        events[`OCX_IRQ_ARMED]   = hwArm && !con2Ff[`OCX_BIT_ARMED];
        events[`OCX_IRQ_TRIGOUT] = offEdge;
    end

    // Read clears, but a new event in the same cycle stays set
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            irqStatFf <= '0;
        else if (rdHit(`OCX_IDX_IRQ_STAT))
            irqStatFf <= events;
        else
            irqStatFf <= irqStatFf | events;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            irqMaskFf <= '0;
        else if (wrHit(`OCX_IDX_IRQ_MASK))
            irqMaskFf <= regWrData[`OCX_IRQ_WIDTH-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(irqStatFf & irqMaskFf);
    end

    // ======================================================================
    // Read port
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            regRdData_ff <= 16'h0000;
        else if (!regRd)
            regRdData_ff <= 16'h0000;
        else
        begin
            case (regAddr)
                `OCX_IDX_CON2:     regRdData_ff <= con2Ff;
                `OCX_IDX_IRQ_STAT: regRdData_ff <= {13'h0000, irqStatFf};
                `OCX_IDX_IRQ_MASK: regRdData_ff <= {13'h0000, irqMaskFf};
                `OCX_IDX_FLT_STAT: regRdData_ff <= {15'h0000, fi.latchFlag};
                default:           regRdData_ff <= 16'h0000;
            endcase
        end
    end

    // ======================================================================
    // Checks
    fault_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        fi.faultActive |=> pinOut_ff == $past(con2Ff[`OCX_BIT_FLT_LEVEL]))
        else $error("fault level not driven");

    fault_float_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        fi.faultActive && con2Ff[`OCX_BIT_FLT_FLOAT] |=> !pinOe_ff)
        else $error("pin not floated on fault");

    fault_drive_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        fi.faultActive && !con2Ff[`OCX_BIT_FLT_FLOAT] && !con2Ff[`OCX_BIT_PIN_FLOAT] |=> pinOe_ff)
        else $error("pin not driven on fault");

    pol_flip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !fi.faultActive |=> pinOut_ff == ($past(compareRaw) ^ $past(con2Ff[`OCX_BIT_POL_FLIP])))
        else $error("compare polarity wrong");

    chain_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWr && (regAddr == `OCX_IDX_CON2) |=> ##1 chainEn_ff == $past(regWrData[`OCX_BIT_CHAIN], 2))
        else $error("cascade enable not following write");

    sync_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !trigMode && selPulse |=> syncPulse_ff)
        else $error("sync pulse missing");

    trig_no_sync_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        trigMode |=> !syncPulse_ff)
        else $error("sync pulse in trigger mode");

    armed_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        hwArm |=> con2Ff[`OCX_BIT_ARMED] ##1 timerRun_ff)
        else $error("armed flag not set by trigger");

    armed_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWr && (regAddr == `OCX_IDX_CON2) && !hwArm |=>
            con2Ff[`OCX_BIT_ARMED] == $past(regWrData[`OCX_BIT_ARMED]))
        else $error("armed flag write lost");

    pin_float_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        con2Ff[`OCX_BIT_PIN_FLOAT] |=> !pinOe_ff)
        else $error("pin not floated");

    unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        con2Ff[11:9] == 3'h0 && regRdData_ff[11:9] == 3'h0)
        else $error("unimplemented bits not zero");

    trig_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        offEdge |=> trigOut_ff ##1 !trigOut_ff)
        else $error("turn-off trigger pulse wrong");

    src_reset_a: assert property (@(posedge ref_clk)
        !reset_n |=> con2Ff == `OCX_CON2_RESET)
        else $error("control reset value wrong");

    fault_enter_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(faultSyncFf) |=> fi.faultActive ##1 !pinOe_ff || pinOut_ff == $past(con2Ff[14]))
        else $error("fault not entered");

endmodule

`default_nettype wire

// ===== ocx_pin_load.sv
// Purpose: External load seen by the compare pin
// Assumes: Weak pull-up on the board trace
// Notes:   A released pin floats up, so it never shows the last driven low
`timescale 1ns/1ps
`default_nettype none

module ocx_pin_load
(
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      pinLevel
);
    // ======================================================================
    // Wire level
    assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule

`default_nettype wire

// ===== ocx_control_two_bench.sv
// Purpose: Self-checking bench for the second compare control block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Outputs are sampled on the falling edge, read data 1 ns after the rising; inputs move on the rising
`timescale 1ns/1ps
`default_nettype none
`include "ocx_params.svh"

module ocx_control_two_bench;
    logic        ref_clk;
    logic        reset_n;
    logic [3:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdData_ff;
    logic        faultPin;
    logic        compareRaw;
    logic        periodStart;
    logic        channelOn;
    logic [31:0] sourcePulse;
    logic        pinOut_ff;
    logic        pinOe_ff;
    logic        chainEn_ff;
    logic        syncPulse_ff;
    logic        timerRun_ff;
    logic        trigOut_ff;
    logic        irq_ff;
    logic        pinLevel;
    logic [15:0] rdVal;
    int          n_errors;
    int          checks;
    int          cycles;

    ocx_control_two ocx_control_two_i
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData_ff(regRdData_ff), .faultPin(faultPin), .compareRaw(compareRaw),
        .periodStart(periodStart), .channelOn(channelOn), .sourcePulse(sourcePulse),
        .pinOut_ff(pinOut_ff), .pinOe_ff(pinOe_ff), .chainEn_ff(chainEn_ff),
        .syncPulse_ff(syncPulse_ff), .timerRun_ff(timerRun_ff),
        .trigOut_ff(trigOut_ff), .irq_ff(irq_ff)
    );

    ocx_pin_load ocx_pin_load_i
    (
        .pinOut(pinOut_ff),
        .pinOe(pinOe_ff),
        .pinLevel(pinLevel)
    );

    // ======================================================================
    // Clock and hang guard
    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    // ======================================================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdData_ff;
        @(posedge ref_clk);
    endtask

    task automatic pulse_period;
        periodStart <= 1'b1;
        @(posedge ref_clk);
        periodStart <= 1'b0;
    endtask

    task automatic end_of_test;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        @(negedge ref_clk);
        chk(pinOe_ff, 1'b1);
        @(posedge ref_clk);
        rd(`OCX_IDX_CON2);
        chk(rdVal, 16'h000C);
        rd(4'h7);
        chk(rdVal, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_fields;
        wr(`OCX_IDX_CON2, 16'hFFFF);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(chainEn_ff, 1'b1);
        chk(timerRun_ff, 1'b1);
        chk(pinOe_ff, 1'b0);
        chk(pinLevel, 1'b1);
        @(posedge ref_clk);
        rd(`OCX_IDX_CON2);
        chk(rdVal, 16'hF1FF);
        wr(`OCX_IDX_CON2, 16'h0000);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(chainEn_ff, 1'b0);
        chk(timerRun_ff, 1'b0);
        chk(pinOe_ff, 1'b1);
        @(posedge ref_clk);
        $display("test fields done");
    endtask

    task automatic t_polarity;
        for (int i = 0; i < 4; i++)
        begin
            wr(`OCX_IDX_CON2, i[1] ? 16'h1000 : 16'h0000);
            compareRaw <= i[0];
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk(pinOut_ff, i[0] ^ i[1]);
            @(posedge ref_clk);
        end
        $display("test polarity done");
    endtask

    task automatic t_trigger;
        wr(`OCX_IDX_IRQ_MASK, 16'h0002);
        @(posedge ref_clk);
        wr(`OCX_IDX_CON2, 16'h0083);
        channelOn   <= 1'b1;
        sourcePulse <= 32'h0000_0010;
        @(posedge ref_clk);
        sourcePulse <= 32'h0000_0008;
        @(posedge ref_clk);
        sourcePulse <= 32'h0000_0000;
        @(negedge ref_clk);
        chk(timerRun_ff, 1'b0);
        chk(syncPulse_ff, 1'b0);
        @(negedge ref_clk);
        chk(timerRun_ff, 1'b1);
        chk(irq_ff, 1'b1);
        @(posedge ref_clk);
        rd(`OCX_IDX_CON2);
        chk(rdVal, 16'h00C3);
        rd(`OCX_IDX_IRQ_STAT);
        chk(rdVal, 16'h0002);
        @(negedge ref_clk);
        chk(irq_ff, 1'b0);
        @(posedge ref_clk);
        wr(`OCX_IDX_CON2, 16'h0003);
        sourcePulse <= 32'h0000_0008;
        @(posedge ref_clk);
        sourcePulse <= 32'h0000_0000;
        @(negedge ref_clk);
        chk(syncPulse_ff, 1'b1);
        @(negedge ref_clk);
        chk(syncPulse_ff, 1'b0);
        chk(timerRun_ff, 1'b0);
        @(posedge ref_clk);
        $display("test trigger done");
    endtask

    task automatic t_turn_off;
        int seen;
        seen = 0;
        wr(`OCX_IDX_IRQ_MASK, 16'h0004);
        @(posedge ref_clk);
        wr(`OCX_IDX_CON2, 16'h0004);
        channelOn <= 1'b0;
        repeat (3)
        begin
            @(negedge ref_clk);
            seen = seen + int'(trigOut_ff);
        end
        chk(16'(seen), 16'h0001);
        chk(irq_ff, 1'b1);
        @(posedge ref_clk);
        rd(`OCX_IDX_IRQ_STAT);
        chk(rdVal, 16'h0004);
        @(negedge ref_clk);
        chk(irq_ff, 1'b0);
        @(posedge ref_clk);
        $display("test turn-off done");
    endtask

    task automatic t_fault_auto;
        for (int lv = 0; lv < 2; lv++)
        begin
            wr(`OCX_IDX_CON2, lv[0] ? 16'h4000 : 16'h0000);
            compareRaw <= ~lv[0];
            faultPin   <= 1'b1;
            repeat (6) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(pinOut_ff, lv[0]);
            chk(pinOe_ff, 1'b1);
            @(posedge ref_clk);
            pulse_period();
            faultPin <= 1'b0;
            repeat (5) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(pinOut_ff, lv[0]);
            @(posedge ref_clk);
            pulse_period();
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk(pinOut_ff, !lv[0]);
            @(posedge ref_clk);
        end
        $display("test fault auto done");
    endtask

    task automatic t_fault_hold;
        rd(`OCX_IDX_IRQ_STAT);
        wr(`OCX_IDX_IRQ_MASK, 16'h0001);
        @(posedge ref_clk);
        wr(`OCX_IDX_CON2, 16'hA000);
        compareRaw <= 1'b0;
        faultPin   <= 1'b1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pinOe_ff, 1'b0);
        chk(pinLevel, 1'b1);
        chk(irq_ff, 1'b1);
        @(posedge ref_clk);
        faultPin <= 1'b0;
        repeat (5) @(posedge ref_clk);
        pulse_period();
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pinOe_ff, 1'b0);
        @(posedge ref_clk);
        rd(`OCX_IDX_FLT_STAT);
        chk(rdVal, 16'h0001);
        wr(`OCX_IDX_FLT_STAT, 16'h0001);
        pulse_period();
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pinOe_ff, 1'b1);
        chk(pinOut_ff, 1'b0);
        @(posedge ref_clk);
        $display("test fault hold done");
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        reset_n     <= 1'b0;
        regAddr     <= 4'h0;
        regWrData   <= 16'h0000;
        regWr       <= 1'b0;
        regRd       <= 1'b0;
        faultPin    <= 1'b0;
        compareRaw  <= 1'b0;
        periodStart <= 1'b0;
        channelOn   <= 1'b0;
        sourcePulse <= 32'h0000_0000;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_fields();
        t_polarity();
        t_trigger();
        t_turn_off();
        t_fault_auto();
        t_fault_hold();
        end_of_test();
    end
endmodule

`default_nettype wire
